// ==== shared/arw_regs.svh ====
// Register offsets, field positions and reset values of the converter result/window block.
// Assumes a byte-wide register port with byte offsets as addresses.
`ifndef ARW_REGS_SVH
`define ARW_REGS_SVH
`define ARW_OFS_STATUS     8'h0B
`define ARW_OFS_DEBUG_HALT_CONTROL    8'h0C
`define ARW_OFS_STAGE      8'h0D
`define ARW_OFS_RES_L      8'h10
`define ARW_OFS_RES_H      8'h11
`define ARW_OFS_WLT_L      8'h12
`define ARW_OFS_WLT_H      8'h13
`define ARW_OFS_WHT_L      8'h14
`define ARW_OFS_WHT_H      8'h15
`define ARW_OFS_CLOCK_DUTY_CALIBRATION      8'h16
`define ARW_OFS_MASK       8'h17
`define ARW_OFS_MODE       8'h18
`define ARW_OFS_ACCUM      8'h19
`define ARW_BIT_RDY        0
`define ARW_BIT_WIN        1
`define ARW_CLOCK_DUTY_CALIBRATION_RST      1'h1
`define ARW_SAMPLE_MAX     10'h3FF
`define ARW_SAMPLE_MIN     10'h000
`define ARW_ACC_MAX_LOG2   3'h6
`define ARW_DIV_PERIOD     4'h4
`define ARW_DIV_QUARTER    4'h1
`define ARW_DIV_HALF       4'h2
`define ARW_BYTE_ZERO      8'h00
`endif

// ==== shared/arw_pkg.sv ====
// Types of the converter result/window block.
// Assumes arw_regs.svh supplies the numeric constants.
package arw_pkg;
	typedef enum logic [2:0] {
		ARW_WIN_NONE, ARW_WIN_BELOW, ARW_WIN_ABOVE, ARW_WIN_INSIDE, ARW_WIN_OUTSIDE
	} arw_win_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} arw_bus_req_t;

	typedef struct packed {
		logic       valid;
		logic [9:0] code;
		logic       over;
		logic       under;
	} arw_sample_t;

	typedef struct packed {
		logic        halt_override;
		logic [7:0]  stage;
		logic [15:0] result;
		logic [15:0] win_low;
		logic [15:0] win_high;
		logic        duty_sel;
		logic [1:0]  flags;
		logic [1:0]  mask;
		logic [2:0]  mode;
		logic [2:0]  acc_log2;
		logic [15:0] acc_sum;
		logic [6:0]  acc_cnt;
		logic [7:0]  rdata;
		logic        irq;
		logic [3:0]  div_cnt;
		logic        conv_clk;
		logic        run;
	} arw_state_t;
endpackage

// ==== hdl/arw_core.sv ====
// Result register, byte staging, window comparator and converter clock of the converter.
// Assumes samples arrive on clk from the analog core and software uses the byte port.
//
// Contract
// - Override clear: halt and ignore events in debug
// - Override set: keep running in debug
// - One shared readable writable staging byte
// - Low byte at base, high at base+1
// - Ten-bit sample in result bits 9:0
// - Over reference gives 0x3FF
// - Below zero gives zero
// - Up to 64 accumulations, at most 0xFFC0
// - Unsigned format, zeros zero, ones full
// - Result read-only, holds latest value
// - Low threshold feeds comparator
// - High threshold feeds comparator
// - Compare final accumulated value only
// - Duty select one: quarter high clock
// - Compare at completion, flag on match
// - Modes: 1 below, 3 inside, 4 outside
// - Result read clears both flags
`timescale 1ns/1ps
`include "arw_regs.svh"
module arw_core (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// Register port
	input  wire arw_pkg::arw_bus_req_t bus,
	output logic [7:0]            rdata,
	// Analog core and debug
	input  wire arw_pkg::arw_sample_t  sample,
	input  wire logic             cpu_halted,
	input  wire logic             start_event,
	// Outputs
	output logic                  conv_clk,
	output logic                  conv_start,
	output logic                  irq
);
	import arw_pkg::*;

	arw_state_t st_ff;
	arw_state_t nxt_st;
	logic       start_ff;
	logic       nxt_start;
	logic [9:0] code;
	logic [15:0] sum_next;
	logic       last;
	logic       below;
	logic       above;
	logic       match;
	logic [6:0] acc_target;

	always_comb begin
		nxt_st = st_ff;
		nxt_start = 1'b0;
		code = sample.code;
		sum_next = st_ff.acc_sum;
		last = 1'b0;
		below = 1'b0;
		above = 1'b0;
		match = 1'b0;
		acc_target = 7'h01 << st_ff.acc_log2;
		nxt_st.run = st_ff.halt_override || !cpu_halted;
		// Converter clock divider, frozen while halted without override
		if (nxt_st.run) begin
			nxt_st.div_cnt = (st_ff.div_cnt == `ARW_DIV_PERIOD - 4'h1) ? 4'h0 : st_ff.div_cnt + 4'h1;
			if (st_ff.duty_sel)
				nxt_st.conv_clk = nxt_st.div_cnt < `ARW_DIV_QUARTER;
			else
				nxt_st.conv_clk = nxt_st.div_cnt < `ARW_DIV_HALF;
			nxt_start = start_event;
		end
		// Sample saturation and accumulation
		if (sample.over)
			code = `ARW_SAMPLE_MAX;
		else if (sample.under)
			code = `ARW_SAMPLE_MIN;
		if (sample.valid && st_ff.run) begin
			sum_next = st_ff.acc_sum + {6'h00, code};
			last = (st_ff.acc_cnt + 7'h01) >= acc_target;
			if (last) begin
				nxt_st.acc_sum = 16'h0000;
				nxt_st.acc_cnt = 7'h00;
				nxt_st.result = sum_next;
			end else begin
				nxt_st.acc_sum = sum_next;
				nxt_st.acc_cnt = st_ff.acc_cnt + 7'h01;
			end
		end
		below = sum_next < st_ff.win_low;
		above = sum_next > st_ff.win_high;
		case (arw_win_mode_t'(st_ff.mode))
			ARW_WIN_BELOW: match = below;
			ARW_WIN_ABOVE: match = above;
			ARW_WIN_INSIDE: match = !below && !above && sum_next != st_ff.win_low && sum_next != st_ff.win_high;
			ARW_WIN_OUTSIDE: match = below || above;
			default: match = 1'b0;
		endcase
		// Register port
		nxt_st.rdata = `ARW_BYTE_ZERO;
		if (bus.rd) begin
			if (bus.addr == `ARW_OFS_STATUS)
				nxt_st.rdata = {6'h00, st_ff.flags};
			else if (bus.addr == `ARW_OFS_DEBUG_HALT_CONTROL)
				nxt_st.rdata = {7'h00, st_ff.halt_override};
			else if (bus.addr == `ARW_OFS_STAGE)
				nxt_st.rdata = st_ff.stage;
			else if (bus.addr == `ARW_OFS_RES_L) begin
				nxt_st.rdata = st_ff.result[7:0];
				nxt_st.stage = st_ff.result[15:8];
				nxt_st.flags = 2'b00;
			end else if (bus.addr == `ARW_OFS_RES_H) begin
				nxt_st.rdata = st_ff.result[15:8];
				nxt_st.flags = 2'b00;
			end else if (bus.addr == `ARW_OFS_WLT_L) begin
				nxt_st.rdata = st_ff.win_low[7:0];
				nxt_st.stage = st_ff.win_low[15:8];
			end else if (bus.addr == `ARW_OFS_WLT_H)
				nxt_st.rdata = st_ff.win_low[15:8];
			else if (bus.addr == `ARW_OFS_WHT_L) begin
				nxt_st.rdata = st_ff.win_high[7:0];
				nxt_st.stage = st_ff.win_high[15:8];
			end else if (bus.addr == `ARW_OFS_WHT_H)
				nxt_st.rdata = st_ff.win_high[15:8];
			else if (bus.addr == `ARW_OFS_CLOCK_DUTY_CALIBRATION)
				nxt_st.rdata = {7'h00, st_ff.duty_sel};
			else if (bus.addr == `ARW_OFS_MASK)
				nxt_st.rdata = {6'h00, st_ff.mask};
			else if (bus.addr == `ARW_OFS_MODE)
				nxt_st.rdata = {5'h00, st_ff.mode};
			else if (bus.addr == `ARW_OFS_ACCUM)
				nxt_st.rdata = {5'h00, st_ff.acc_log2};
		end
		if (bus.wr) begin
			if (bus.addr == `ARW_OFS_STATUS)
				nxt_st.flags = st_ff.flags & ~bus.wdata[1:0];
			else if (bus.addr == `ARW_OFS_DEBUG_HALT_CONTROL)
				nxt_st.halt_override = bus.wdata[0];
			else if (bus.addr == `ARW_OFS_STAGE || bus.addr == `ARW_OFS_WLT_L || bus.addr == `ARW_OFS_WHT_L)
				nxt_st.stage = bus.wdata;
			else if (bus.addr == `ARW_OFS_WLT_H)
				nxt_st.win_low = {bus.wdata, st_ff.stage};
			else if (bus.addr == `ARW_OFS_WHT_H)
				nxt_st.win_high = {bus.wdata, st_ff.stage};
			else if (bus.addr == `ARW_OFS_CLOCK_DUTY_CALIBRATION)
				nxt_st.duty_sel = bus.wdata[0];
			else if (bus.addr == `ARW_OFS_MASK)
				nxt_st.mask = bus.wdata[1:0];
			else if (bus.addr == `ARW_OFS_MODE)
				nxt_st.mode = bus.wdata[2:0];
			else if (bus.addr == `ARW_OFS_ACCUM)
				nxt_st.acc_log2 = (bus.wdata[2:0] > `ARW_ACC_MAX_LOG2) ? `ARW_ACC_MAX_LOG2 : bus.wdata[2:0];
		end
		// Flag set wins over any clear
		if (sample.valid && st_ff.run && last) begin
			nxt_st.flags[`ARW_BIT_RDY] = 1'b1;
			if (match)
				nxt_st.flags[`ARW_BIT_WIN] = 1'b1;
		end
		nxt_st.irq = |(nxt_st.flags & nxt_st.mask);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_ff <= '0;
			st_ff.duty_sel <= `ARW_CLOCK_DUTY_CALIBRATION_RST;
			st_ff.run <= 1'b1;
			start_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			start_ff <= nxt_start;
		end
	end

	assign rdata = st_ff.rdata;
	assign conv_clk = st_ff.conv_clk;
	assign conv_start = start_ff;
	assign irq = st_ff.irq;

	a_halt_blocks: assert property (@(posedge clk) disable iff (reset)
		(!st_ff.halt_override && cpu_halted) |=> !conv_start) else $error("event passed while halted");
	a_run_passes: assert property (@(posedge clk) disable iff (reset)
		(st_ff.halt_override && start_event) |=> conv_start) else $error("event lost with override");
	a_res_clear: assert property (@(posedge clk) disable iff (reset)
		(bus.rd && bus.addr == `ARW_OFS_RES_L && !sample.valid) |=> st_ff.flags == 2'b00) else $error("flags kept");
	a_res_stage: assert property (@(posedge clk) disable iff (reset)
		(bus.rd && bus.addr == `ARW_OFS_RES_L) |=> st_ff.stage == $past(st_ff.result[15:8])) else $error("stage bad");
	a_wlt_commit: assert property (@(posedge clk) disable iff (reset)
		(bus.wr && bus.addr == `ARW_OFS_WLT_H) |=> st_ff.win_low == {$past(bus.wdata), $past(st_ff.stage)})
		else $error("low threshold commit wrong");
	a_quarter_duty: assert property (@(posedge clk) disable iff (reset)
		(st_ff.duty_sel && st_ff.conv_clk && (st_ff.halt_override || !cpu_halted)) |=> !st_ff.conv_clk)
		else $error("high too long");
	a_res_ceiling: assert property (@(posedge clk) disable iff (reset)
		st_ff.result <= 16'hFFC0) else $error("result above ceiling");
	a_win_flag: assert property (@(posedge clk) disable iff (reset)
		$rose(st_ff.flags[`ARW_BIT_WIN]) |-> $rose(st_ff.flags[`ARW_BIT_RDY]) || st_ff.flags[`ARW_BIT_RDY])
		else $error("match without completion");
	a_irq_level: assert property (@(posedge clk) disable iff (reset)
		##1 irq == |($past(nxt_st.flags) & $past(nxt_st.mask))) else $error("irq mismatch");

	c_result_read: cover property (@(posedge clk) bus.rd && bus.addr == `ARW_OFS_RES_L && st_ff.flags != 2'b00);
	c_win_set: cover property (@(posedge clk) $rose(st_ff.flags[`ARW_BIT_WIN]));
	c_halt: cover property (@(posedge clk) cpu_halted && !st_ff.halt_override && start_event);
	c_thresh_write: cover property (@(posedge clk) bus.wr && bus.addr == `ARW_OFS_WHT_H);
endmodule

// ==== testbench/test_arw_core.sv ====
// Self-checking bench of the converter result/window block.
// Assumes arw_pkg, arw_regs.svh and arw_core are compiled first.
`timescale 1ns/1ps
module test_arw_core;
	import arw_pkg::*;
	logic         clk = 0;
	logic         reset = 1;
	arw_bus_req_t bus = '0;
	arw_sample_t  sample = '0;
	logic         cpu_halted = 0;
	logic         start_event = 0;
	logic [7:0]   rdata;
	logic         conv_clk;
	logic         conv_start;
	logic         irq;
	int           failures = 0;
	int           compares = 0;
	logic [15:0]  v;
	logic [2:0]   md;
	logic         m;
	logic [3:0]   cnt;
	logic [2:0]   modes [3] = '{3'h1, 3'h3, 3'h4};

	arw_core u_arw_core (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .sample(sample),
		.cpu_halted(cpu_halted), .start_event(start_event), .conv_clk(conv_clk),
		.conv_start(conv_start), .irq(irq));

	always #50 clk = ~clk;

	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Byte port cycles
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) bus <= '0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk) bus <= '0;
		#1 chk(rdata, e);
	endtask
	task smp(input logic [9:0] c, input logic o, input logic u);
		@(posedge clk) sample <= '{1'b1, c, o, u};
		@(posedge clk) sample <= '0;
	endtask
	task ev(input logic e);
		@(posedge clk) start_event <= 1'b1;
		@(posedge clk) start_event <= 1'b0;
		#1 chk(conv_start, e);
	endtask
	// High cycles of the converter clock over two periods
	task duty(input logic [3:0] e);
		cnt = 4'h0;
		repeat (8) begin
			@(posedge clk);
			#1 cnt = cnt + conv_clk;
		end
		chk(cnt, e);
	endtask
	task conclude;
		if (failures == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		#1000000;
		failures++;
		conclude;
	end

	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		rd(8'h16, 8'h01);
		rd(8'h0C, 8'h00);
		wr(8'h0D, 8'hA5);
		rd(8'h0D, 8'hA5);
		wr(8'h12, 8'h00);
		wr(8'h13, 8'h01);
		wr(8'h14, 8'h00);
		wr(8'h15, 8'h02);
		rd(8'h12, 8'h00);
		rd(8'h0D, 8'h01);
		rd(8'h14, 8'h00);
		rd(8'h0D, 8'h02);
		wr(8'h10, 8'hFF);
		wr(8'h40, 8'hFF);
		rd(8'h40, 8'h00);
		rd(8'h10, 8'h00);
		wr(8'h17, 8'h03);
		// Window modes against both strict edges
		for (int i = 0; i < 3; i++) begin
			for (int j = 0; j < 5; j++) begin
				md = modes[i];
				v = 16'((j + 1) * 128);
				if (md == 3'h1)
					m = v < 16'h0100;
				else if (md == 3'h3)
					m = v > 16'h0100 && v < 16'h0200;
				else
					m = v < 16'h0100 || v > 16'h0200;
				wr(8'h18, {5'h00, md});
				smp(v[9:0], 1'b0, 1'b0);
				rd(8'h0B, {6'h00, m, 1'b1});
				chk(irq, 1'b1);
				rd(8'h10, v[7:0]);
				rd(8'h0D, v[15:8]);
				rd(8'h0B, 8'h00);
				chk(irq, 1'b0);
			end
		end
		wr(8'h18, 8'h00);
		wr(8'h17, 8'h00);
		smp(10'h155, 1'b1, 1'b0);
		rd(8'h0B, 8'h01);
		chk(irq, 1'b0);
		wr(8'h0B, 8'h01);
		rd(8'h0B, 8'h00);
		rd(8'h10, 8'hFF);
		rd(8'h0D, 8'h03);
		smp(10'h155, 1'b0, 1'b1);
		rd(8'h10, 8'h00);
		rd(8'h0D, 8'h00);
		// Full accumulation of saturated samples
		wr(8'h19, 8'h06);
		wr(8'h18, 8'h02);
		smp(10'h000, 1'b1, 1'b0);
		rd(8'h0B, 8'h00);
		repeat (63) smp(10'h000, 1'b1, 1'b0);
		rd(8'h0B, 8'h03);
		rd(8'h10, 8'hC0);
		rd(8'h0D, 8'hFF);
		wr(8'h19, 8'h00);
		wr(8'h18, 8'h00);
		// Debug halt with and without override
		@(posedge clk) cpu_halted <= 1'b1;
		smp(10'h055, 1'b0, 1'b0);
		rd(8'h0B, 8'h00);
		ev(1'b0);
		wr(8'h0C, 8'h01);
		ev(1'b1);
		smp(10'h055, 1'b0, 1'b0);
		rd(8'h10, 8'h55);
		duty(4'h2);
		@(posedge clk) cpu_halted <= 1'b0;
		wr(8'h0C, 8'h00);
		ev(1'b1);
		duty(4'h2);
		wr(8'h16, 8'h00);
		duty(4'h4);
		conclude;
	end
endmodule
